// >>> rtl/osc_pkg.sv
// Summary of operation
// - Off isolates both pins; raw clock static whichever source is selected.
// - Run request with crystal source selected enters Startup.
// - Output clock gated until counter sees 4096 raw clock cycles.
// - Count done moves Startup to Stable; Stable drives continuous clock.
// - Run request with pad source selected buffers pad clock to output.
// - Crystal mode uses both pins; external mode frees drive pin.
// - No own reset state; counter clears when clocks not requested.
// - Module never issues a reset request.
// - In stop, oscillator runs only if reference enable and keep-alive set.
// - Wake from very low leakage stop returns all bits to reset.
// - Module never raises an interrupt.
// - Reference clock in stop needs keep-alive set, and enable set before stop and held.
// - System clock runs only in run mode; others may run in stop.
package osc_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_REF_EN_BIT = 7;
  localparam int unsigned CTRL_KEEP_BIT = 5;
  localparam int unsigned CTRL_LOAD_LSB = 0;
  localparam int unsigned CTRL_LOAD_W = 4;
  localparam int unsigned CFG_RUN_BIT = 0;
  localparam int unsigned CFG_SRC_BIT = 1;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_DONE_BIT = 2;
  localparam int unsigned STAT_GEN_BIT = 3;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int unsigned STABLE_COUNT = 4096;
  localparam int unsigned COUNT_W = 13;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_STARTUP = 2'b01,
    ST_STABLE = 2'b10,
    ST_EXTCLK = 2'b11
  } osc_state_t;

  typedef struct packed {
    logic hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } ahb_req_t;

  typedef struct packed {
    logic peripheral_ref_enable;
    logic stop_keep_alive;
    logic [CTRL_LOAD_W-1:0] load_select;
  } ctrl_reg_t;

  typedef struct packed {
    logic run_request;
    logic reference_source_select;
  } cfg_reg_t;

endpackage

// >>> rtl/osc_sync2.sv
`timescale 1ns/1ps
module osc_sync2 (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;

  // Only the second stage is visible to other logic
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> rtl/osc_qual_counter.sv
`timescale 1ns/1ps
module osc_qual_counter (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  output logic done
);

  localparam logic [osc_pkg::COUNT_W-1:0] TERMINAL =
    osc_pkg::COUNT_W'(osc_pkg::STABLE_COUNT);

  logic [osc_pkg::COUNT_W-1:0] count_reg;
  logic [osc_pkg::COUNT_W-1:0] count_next;
  wire at_end = (count_reg == TERMINAL);

  assign count_next = at_end ? count_reg : count_reg + 1'b1;

  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && clear))
      count_reg <= '0;
    else if (ce && tick)
      count_reg <= count_next;
  end

  assign done = at_end;

endmodule

// >>> rtl/osc_ctrl.sv
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module osc_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire osc_pkg::ahb_req_t ahb_req,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic raw_crystal_clock,
  input wire logic clock_input_pad,
  input wire logic stop_mode,
  input wire logic very_low_leakage_stop_wake,
  output logic amp_enable,
  output logic pad_isolate,
  output logic drive_output_pad_out,
  output logic drive_output_pad_oe,
  output logic [3:0] load_select,
  output logic osc_clk_out,
  output logic system_crystal_clock,
  output logic peripheral_reference_clock,
  output logic slow_32k_output,
  output logic stable_count_done,
  output logic reset_request,
  output logic irq
);

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  osc_pkg::ctrl_reg_t ctrl_reg;
  osc_pkg::cfg_reg_t cfg_reg;
  osc_pkg::osc_state_t state_reg;
  osc_pkg::osc_state_t state_next;
  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic [31:0] rdata_next;

  wire addr_phase = ahb_req.hsel && hready && ahb_req.htrans[1];
  wire [7:0] req_ofs = ahb_req.haddr[7:0];
  wire wr_ctrl = wr_pend_reg && (wr_ofs_reg == osc_pkg::OFS_CTRL);
  wire wr_cfg = wr_pend_reg && (wr_ofs_reg == osc_pkg::OFS_CFG);

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic [31:0] read_mux(
    input logic [7:0] ofs,
    input osc_pkg::ctrl_reg_t c,
    input osc_pkg::cfg_reg_t g,
    input logic [1:0] st,
    input logic dn,
    input logic gen
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      osc_pkg::OFS_CTRL:
      begin
        v[osc_pkg::CTRL_REF_EN_BIT] = c.peripheral_ref_enable;
        v[osc_pkg::CTRL_KEEP_BIT] = c.stop_keep_alive;
        v[osc_pkg::CTRL_LOAD_LSB +: osc_pkg::CTRL_LOAD_W] = c.load_select;
      end
      osc_pkg::OFS_CFG:
      begin
        v[osc_pkg::CFG_RUN_BIT] = g.run_request;
        v[osc_pkg::CFG_SRC_BIT] = g.reference_source_select;
      end
      osc_pkg::OFS_STATUS:
      begin
        v[osc_pkg::STAT_STATE_LSB +: 2] = st;
        v[osc_pkg::STAT_DONE_BIT] = dn;
        v[osc_pkg::STAT_GEN_BIT] = gen;
      end
      default:
        v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_phase && ahb_req.hwrite;
      wr_ofs_reg <= req_ofs;
    end
  end

  // ---------------------------------------------------------------
  // Control and configuration bits
  // ---------------------------------------------------------------
  // Wake-up clear beats a write in the same cycle
  // wake restores resets
  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && very_low_leakage_stop_wake))
    begin
      ctrl_reg <= osc_pkg::ctrl_reg_t'(6'(osc_pkg::CTRL_RESET));
      cfg_reg <= osc_pkg::cfg_reg_t'(osc_pkg::CFG_RESET);
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        ctrl_reg.peripheral_ref_enable <= hwdata[osc_pkg::CTRL_REF_EN_BIT];
        ctrl_reg.stop_keep_alive <= hwdata[osc_pkg::CTRL_KEEP_BIT];
        ctrl_reg.load_select <=
          hwdata[osc_pkg::CTRL_LOAD_LSB +: osc_pkg::CTRL_LOAD_W];
      end
      if (wr_cfg)
      begin
        cfg_reg.run_request <= hwdata[osc_pkg::CFG_RUN_BIT];
        cfg_reg.reference_source_select <= hwdata[osc_pkg::CFG_SRC_BIT];
      end
    end
  end

  assign load_select = ctrl_reg.load_select;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic raw_sync;
  logic pad_sync;
  logic raw_prev_reg;

  osc_sync2 u_raw_sync (
    .sys_clk(sys_clk),
    .ce(ce),
    .rst(rst),
    .async_in(raw_crystal_clock),
    .sync_out(raw_sync)
  );

  osc_sync2 u_pad_sync (
    .sys_clk(sys_clk),
    .ce(ce),
    .rst(rst),
    .async_in(clock_input_pad),
    .sync_out(pad_sync)
  );

  // ---------------------------------------------------------------
  // Stop handling
  // ---------------------------------------------------------------
  // Enable captured on stop entry, held through stop
  logic ref_at_stop_reg;
  logic stop_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ref_at_stop_reg <= 1'b0;
      stop_reg <= 1'b0;
    end
    else if (ce)
    begin
      stop_reg <= stop_mode;
      if (!stop_mode)
        ref_at_stop_reg <= ctrl_reg.peripheral_ref_enable;
    end
  end

  wire ref_kept =
    ctrl_reg.stop_keep_alive && ref_at_stop_reg &&
    ctrl_reg.peripheral_ref_enable;
  wire stop_allows = !stop_mode || ref_kept;
  wire gen_req = cfg_reg.run_request && stop_allows;
  wire src_drive_output_pad = cfg_reg.reference_source_select;

  // ---------------------------------------------------------------
  // Qualification counter
  // ---------------------------------------------------------------
  // Counting only while amplifier is up
  wire amp_on = gen_req && src_drive_output_pad;
  wire raw_gated = amp_on && raw_sync;
  wire raw_rise = raw_gated && !raw_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      raw_prev_reg <= 1'b0;
    else if (ce)
      raw_prev_reg <= raw_gated;
  end

  osc_qual_counter u_counter (
    .sys_clk(sys_clk),
    .ce(ce),
    .rst(rst),
    .clear(!amp_on),
    .tick(raw_rise),
    .done(stable_count_done)
  );

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always_comb
  begin
    case (state_reg)
      osc_pkg::ST_OFF,
      osc_pkg::ST_STARTUP,
      osc_pkg::ST_STABLE,
      osc_pkg::ST_EXTCLK:
      begin
        if (!gen_req)
          state_next = osc_pkg::ST_OFF;
        else if (!src_drive_output_pad)
          state_next = osc_pkg::ST_EXTCLK;
        else if (state_reg == osc_pkg::ST_OFF ||
                 state_reg == osc_pkg::ST_EXTCLK)
          state_next = osc_pkg::ST_STARTUP;
        else if (stable_count_done)
          state_next = osc_pkg::ST_STABLE;
        else
          state_next = osc_pkg::ST_STARTUP;
      end
      default:
        state_next = osc_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= osc_pkg::ST_OFF;
    else if (ce)
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Pins and output clocks
  // ---------------------------------------------------------------
  wire in_drive_output_pad = (state_reg == osc_pkg::ST_STARTUP) ||
                 (state_reg == osc_pkg::ST_STABLE);
  wire clk_next =
    (state_reg == osc_pkg::ST_STABLE) ? raw_sync :
    (state_reg == osc_pkg::ST_EXTCLK) ? pad_sync : 1'b0;
  wire sys_next = clk_next && !stop_mode;
  wire ref_next = clk_next && ctrl_reg.peripheral_ref_enable &&
                  (!stop_mode || ref_kept);
  wire slow_next = clk_next;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      osc_clk_out <= 1'b0;
      system_crystal_clock <= 1'b0;
      peripheral_reference_clock <= 1'b0;
      slow_32k_output <= 1'b0;
      drive_output_pad_out <= 1'b0;
      drive_output_pad_oe <= 1'b0;
      amp_enable <= 1'b0;
      pad_isolate <= 1'b1;
      hrdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      osc_clk_out <= clk_next;
      system_crystal_clock <= sys_next;
      peripheral_reference_clock <= ref_next;
      slow_32k_output <= slow_next;
      // drive pin only in crystal mode
      drive_output_pad_out <= in_drive_output_pad && !raw_sync;
      drive_output_pad_oe <= state_next == osc_pkg::ST_STARTUP ||
                             state_next == osc_pkg::ST_STABLE;
      amp_enable <= amp_on;
      pad_isolate <= state_next == osc_pkg::ST_OFF;
      hrdata <= rdata_next;
    end
  end

  assign rdata_next = (addr_phase && !ahb_req.hwrite) ?
    read_mux(req_ofs, ctrl_reg, cfg_reg, state_reg,
             stable_count_done, gen_req) : 32'h0000_0000;

  assign reset_request = 1'b0;
  assign irq = 1'b0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence seq_qualified;
    ce && state_reg == osc_pkg::ST_STARTUP && stable_count_done &&
    gen_req && src_drive_output_pad;
  endsequence

  sequence seq_into_stable;
    state_reg == osc_pkg::ST_STABLE ##1 osc_clk_out == $past(raw_sync);
  endsequence

  a_off_isolate: assert property (@(posedge sys_clk) disable iff (rst)
    ce |=> pad_isolate == (state_reg == osc_pkg::ST_OFF) &&
    (!pad_isolate || !amp_enable))
    else $error("pins not isolated in off");

  a_startup_entry: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_reg == osc_pkg::ST_OFF && gen_req && src_drive_output_pad
    |=> state_reg == osc_pkg::ST_STARTUP)
    else $error("startup not entered");

  a_gate_startup: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_reg == osc_pkg::ST_STARTUP |=> !osc_clk_out)
    else $error("clock passed before qualification");

  a_stable_entry: assert property (@(posedge sys_clk) disable iff (rst)
    seq_qualified ##1 ce |-> seq_into_stable)
    else $error("stable clock not delivered");

  a_ext_follow: assert property (@(posedge sys_clk) disable iff (rst)
    ce && gen_req && !src_drive_output_pad ##1 ce |-> state_reg == osc_pkg::ST_EXTCLK
    ##1 osc_clk_out == $past(pad_sync))
    else $error("pad clock not buffered");

  a_pin_use: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == osc_pkg::ST_EXTCLK |-> !drive_output_pad_oe)
    else $error("drive pin busy in external mode");

  a_count_clear: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !amp_on |=> !stable_count_done)
    else $error("counter not cleared");

  a_no_reset: assert property (@(posedge sys_clk) disable iff (rst)
    !reset_request && !irq)
    else $error("reset or interrupt raised");

  a_stop_gate: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_mode && !(ctrl_reg.stop_keep_alive &&
    ctrl_reg.peripheral_ref_enable) |=> state_reg == osc_pkg::ST_OFF)
    else $error("oscillator kept in stop");

  a_wake_reset: assert property (@(posedge sys_clk) disable iff (rst)
    ce && very_low_leakage_stop_wake |=> !cfg_reg.run_request &&
    !ctrl_reg.peripheral_ref_enable && ctrl_reg.load_select == 4'h0)
    else $error("wake did not reset bits");

  a_ref_in_stop: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_mode && !ctrl_reg.stop_keep_alive
    |=> !peripheral_reference_clock)
    else $error("reference clock on in stop");

  a_sys_run_only: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_mode |=> !system_crystal_clock)
    else $error("system clock in stop");

  a_done_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stable_count_done && amp_on ##1 amp_on |-> stable_count_done)
    else $error("done dropped while requested");

endmodule

// >>> verification/osc_source_model.sv
`timescale 1ns/1ps
module osc_source_model (
  input wire logic amp_enable,
  input wire logic pad_run,
  output logic raw_crystal_clock,
  output logic clock_input_pad
);
  // -------------------------------------------
  // Sources
  // -------------------------------------------
  // Half periods above two sys_clk periods for the synchronisers
  localparam time DRIVE_OUTPUT_PAD_HALF = 300ns;
  // Edges kept off every sys_clk rising edge
  localparam time PAD_HALF = 320ns;
  initial
  begin
    raw_crystal_clock = 1'b0;
    clock_input_pad = 1'b0;
  end
  always
  begin
    #(DRIVE_OUTPUT_PAD_HALF);
    if (amp_enable === 1'b1)
      raw_crystal_clock = ~raw_crystal_clock;
  end
  // pad source stands still when stopped
  always
  begin
    #(PAD_HALF);
    if (pad_run)
      clock_input_pad = ~clock_input_pad;
  end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic stop_mode = 1'b0;
  logic wake = 1'b0;
  logic pad_run = 1'b0;
  osc_pkg::ahb_req_t ahb_req = '0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [3:0] load_select;
  logic hready, hresp, amp_enable, pad_isolate, pad_out, pad_oe;
  logic osc_clk_out, sys_drive_output_pad, ref_clk, slow_clk, done, rst_req, irq;
  logic raw_crystal_clock, clock_input_pad;
  logic bad_out = 1'b0;
  logic ce = 1'b1;
  int n_slow = 0;
  int n_drv = 0;
  logic [7:0] stop_ctrl [3] = '{8'ha0, 8'h80, 8'h20};
  logic stop_amp [3] = '{1'b1, 1'b0, 1'b0};
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n_raw = 0;
  int n_out = 0;
  int n_ref = 0;
  int n_sys = 0;
  int k;

  always #50 sys_clk = ~sys_clk;

  osc_ctrl u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .ahb_req(ahb_req),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hready),
    .hresp(hresp),
    .hrdata(hrdata),
    .raw_crystal_clock(raw_crystal_clock),
    .clock_input_pad(clock_input_pad),
    .stop_mode(stop_mode),
    .very_low_leakage_stop_wake(wake),
    .amp_enable(amp_enable),
    .pad_isolate(pad_isolate),
    .drive_output_pad_out(pad_out),
    .drive_output_pad_oe(pad_oe),
    .load_select(load_select),
    .osc_clk_out(osc_clk_out),
    .system_crystal_clock(sys_drive_output_pad),
    .peripheral_reference_clock(ref_clk),
    .slow_32k_output(slow_clk),
    .stable_count_done(done),
    .reset_request(rst_req),
    .irq(irq)
  );

  osc_source_model u_src (
    .amp_enable(amp_enable),
    .pad_run(pad_run),
    .raw_crystal_clock(raw_crystal_clock),
    .clock_input_pad(clock_input_pad)
  );

  // -------------------------------------------
  // Monitors
  // -------------------------------------------
  always @(posedge raw_crystal_clock) n_raw++;
  always @(posedge osc_clk_out) n_out++;
  always @(posedge ref_clk) n_ref++;
  always @(posedge sys_drive_output_pad) n_sys++;
  always @(posedge slow_clk) n_slow++;
  always @(posedge pad_out) n_drv++;
  always @(posedge sys_clk)
  begin
    if (!rst && (rst_req !== 1'b0 || irq !== 1'b0))
      bad_out <= 1'b1;
    cyc++;
    // Startup alone is near 25k cycles
    if (cyc == 60000)
    begin
      n_fail++;
      conclude();
    end
  end

  // -------------------------------------------
  // Tasks
  // -------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    ahb_req <= '{1'b1, {24'h0, a}, 2'b10, w, 3'h2};
    do @(posedge sys_clk); while (hready !== 1'b1);
    ahb_req <= '{1'b0, {24'h0, a}, 2'b00, 1'b0, 3'h2};
    hwdata <= d;
    do
    begin
      @(posedge sys_clk);
      q = hrdata;
    end
    while (hready !== 1'b1);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
    xfer(1'b0, a, 32'h0);
    check(q, exp, what);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // -------------------------------------------
  // Sequence
  // -------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(pad_isolate, 1'b1, "isolate after reset");
    check(osc_clk_out, 1'b0, "clock after reset");
    rd_check(osc_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    xfer(1'b1, osc_pkg::OFS_CTRL, 32'hffffffff);
    rd_check(osc_pkg::OFS_CTRL, 32'haf, "ctrl reserved bits");
    check(load_select, 4'hf, "load select");
    xfer(1'b1, osc_pkg::OFS_STATUS, 32'hf);
    rd_check(osc_pkg::OFS_STATUS, 32'h0, "status read only");
    rd_check(8'h0c, 32'h0, "unmapped read");
    check(hresp, 1'b0, "okay response");
    xfer(1'b1, osc_pkg::OFS_CTRL, 32'h0);
    // Crystal startup, raw edges counted from amplifier on
    n_raw = 0;
    n_out = 0;
    xfer(1'b1, osc_pkg::OFS_CFG, 32'h3);
    idle(5);
    rd_check(osc_pkg::OFS_STATUS, 32'h9, "startup state");
    check(pad_isolate, 1'b0, "pins coupled");
    check(pad_oe, 1'b1, "drive pad used");
    k = 0;
    while (done !== 1'b1 && k < 40000)
    begin
      @(posedge sys_clk);
      k++;
    end
    check(n_raw, osc_pkg::STABLE_COUNT, "edges at done");
    check(n_out, 0, "gated before done");
    idle(4);
    rd_check(osc_pkg::OFS_STATUS, 32'he, "stable state");
    n_out = 0;
    n_sys = 0;
    n_slow = 0;
    n_ref = 0;
    n_drv = 0;
    idle(50);
    check(n_out > 0, 1'b1, "stable clock runs");
    check(n_sys > 0, 1'b1, "system clock in run");
    check(n_slow > 0, 1'b1, "slow clock in run");
    check(n_ref, 0, "ref clock without enable");
    check(n_drv > 0, 1'b1, "drive pad swings");
    check(done, 1'b1, "done held");
    // Clock enable low freezes every output flop
    ce <= 1'b0;
    idle(2);
    n_out = 0;
    idle(20);
    check(n_out, 0, "frozen output clock");
    check(done, 1'b1, "done kept while frozen");
    ce <= 1'b1;
    idle(2);
    // stop with keep-alive and enable, enable only, keep-alive only
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, osc_pkg::OFS_CTRL, {24'h0, stop_ctrl[i]});
      idle(3);
      stop_mode <= 1'b1;
      idle(5);
      n_ref = 0;
      n_sys = 0;
      n_slow = 0;
      idle(50);
      check(amp_enable, stop_amp[i], "amp in stop");
      check(n_ref > 0, stop_amp[i], "ref clock in stop");
      check(n_sys, 0, "system clock in stop");
      check(n_slow > 0, stop_amp[i], "slow clock in stop");
      stop_mode <= 1'b0;
      idle(2);
    end
    xfer(1'b1, osc_pkg::OFS_CFG, 32'h1);
    pad_run <= 1'b1;
    idle(5);
    rd_check(osc_pkg::OFS_STATUS, 32'hb, "external state");
    check(pad_oe, 1'b0, "drive pad free");
    check(amp_enable, 1'b0, "amp off external");
    check(pad_out, 1'b0, "drive pad idle");
    n_out = 0;
    idle(50);
    check(n_out > 0, 1'b1, "pad clock passed");
    xfer(1'b1, osc_pkg::OFS_CFG, 32'h0);
    pad_run <= 1'b0;
    idle(5);
    rd_check(osc_pkg::OFS_STATUS, 32'h0, "off clears count");
    check(pad_isolate, 1'b1, "pins isolated");
    check(amp_enable, 1'b0, "raw clock static");
    xfer(1'b1, osc_pkg::OFS_CTRL, 32'haf);
    xfer(1'b1, osc_pkg::OFS_CFG, 32'h2);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    idle(2);
    rd_check(osc_pkg::OFS_CTRL, 32'h0, "ctrl after wake");
    rd_check(osc_pkg::OFS_CFG, 32'h0, "cfg after wake");
    check(load_select, 4'h0, "load after wake");
    check(bad_out, 1'b0, "no reset or irq");
    conclude();
  end
endmodule
